// [design/diag_scan_scheduler.sv]
// Periodic diagnostic scan scheduler with APB registers
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
`include "diag_scan_defines.svh"

// Overview of operation
// - Balancing over/undercurrent checked only for cells balancing at scan start.
// - Unmasked overcurrent filtering (mask bit 7 clear) clears a cell counter when its balancing stops.
// - If balancing stops on all cells, nonzero cell counters are kept.
// - A scan starts right after wake-up, then repeats periodically.
// - Programmed cycle wait count sets the gap between scans.
// - Inter-cycle counter reloads from wait count when each scan starts.
// - One filter counter per general fault and per balancing cell, incremented per detecting scan.
// - Flag set when counter exceeds consecutive fault limit.
// - Flag set and not escalation-masked starts emergency signalling.
// - Counter cleared after a scan without that fault.
// - Counter cleared when host clears the matching flag.
// - Counters survive sleep; only normal-mode conditions clear them.
// - Temperature counter counts scans, triggers NTC measure at one (or zero), reloads.
// - With sync set, watchdog write starts a scan and reloads wait.
// - Sleep runs no checks except the periodic single scan.
// - Periodic sleep scan without flags returns to sleep at once.
// - Periodic wake-up off after reset; nonzero interval enables it.
// - External wake-up during the periodic sleep scan goes to normal mode.
// - Sleep scan flag: emergency signal then sleep, or fault pin then sleep.
// - First scan after any wake-up skips NTC measurement.
// - NTC current sources on about 40 ms before measuring scan.
// - Each sleep interval step is 10 min.
module diag_scan_scheduler
   import diag_scan_pkg::*;
#(
   parameter int unsigned      WAIT_STEP_CYC  = `WAIT_STEP_US * 1000 / `CLK_NS,
   parameter int unsigned      SETTLE_CYC     = `SETTLE_MS * 1000000 / `CLK_NS,
   parameter int unsigned      WD_MAX_CYC     = `WD_MAX_MS * 1000000 / `CLK_NS,
   parameter longint unsigned  SLEEP_STEP_CYC =
      64'(`SLEEP_STEP_MIN) * 64'd60 * 64'd1000000000 / 64'(`CLK_NS)
)(
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [11:0]  paddr,
   input  wire logic [31:0]  pwdata,
   output logic      [31:0]  prdata,
   output logic              pready,
   output logic              pslverr,
   input  wire logic         wake_done,
   input  wire logic         sleep_req,
   input  wire logic         ext_wakeup,
   input  wire logic         scan_done,
   input  wire scan_result_t scan_result,
   input  wire logic [11:0]  balance_en,
   input  wire logic         emm_sent,
   output logic              scan_start,
   output logic              ntc_measure,
   output logic              ntc_current_on,
   output logic              emergency_signalling,
   output logic              fault_pin
);

   // Saturating filter count step
   function automatic logic [2:0] sat_inc(input logic [2:0] c);
      sat_inc = (c == 3'h7) ? c : c + 3'h1;
   endfunction
   // Filter trips when masked or incremented count passes limit
   function automatic logic trip(input logic [2:0] c, input logic [2:0] lim,
                                 input logic m);
      trip = m | (sat_inc(c) > lim);
   endfunction

   sched_state_t state_reg;
   sched_state_t state_next;
   logic [6:0]   wait_cnt_reg;
   logic         sync_reg;
   logic [7:0]   filt_mask_reg;
   logic [3:0]   ntc_div_reg;
   logic [2:0]   limit_reg;
   logic [9:0]   sleep_ivl_reg;
   logic [7:0]   esc_mask_reg;
   logic [7:0]   flags_reg;
   logic [7:0]   flags_next;
   logic [6:0]   wd_reg;
   logic [31:0]  wait_cyc_reg;
   logic [63:0]  sleep_cyc_reg;
   logic [3:0]   temp_cnt_reg;
   logic         wake_pend_reg;
   logic         hold_emm_reg;
   logic [11:0]  bal_snap_reg;
   logic [11:0]  bal_prev_reg;
   logic [2:0]   gen_cnt_reg [6];
   logic [2:0]   bal_cnt_reg [12];
   logic [31:0]  prdata_reg;
   logic         pready_reg;
   logic         pslverr_reg;
   logic         scan_start_reg;
   logic         ntc_meas_reg;
   logic         ntc_on_reg;
   logic         emm_reg;
   logic         fault_pin_reg;
   logic [7:0]   set_vec;
   logic [11:0]  bal_uc_trip;
   logic [11:0]  bal_oc_trip;

   // APB decode
   wire        setup    = psel & ~penable;
   wire        wr_acc   = psel & penable & pready_reg & pwrite;
   wire        hit_sch  = paddr == `OFS_SCHED;
   wire        hit_filt = paddr == `OFS_FILT;
   wire        hit_esc  = paddr == `OFS_ESC_MASK;
   wire        hit_diag = paddr == `OFS_DIAG;
   wire        hit_wd   = paddr == `OFS_WD;
   wire        hit_st   = paddr == `OFS_STATUS;
   wire        mapped   = hit_sch | hit_filt | hit_esc | hit_diag | hit_wd | hit_st;
   wire [7:0]  clr_vec  = (wr_acc & hit_diag) ? pwdata[7:0] : 8'h00;

   // Read data selection
   wire [31:0] rd_sch  = {12'h000, ntc_div_reg, filt_mask_reg, sync_reg, wait_cnt_reg};
   wire [31:0] rd_filt = {18'h00000, sleep_ivl_reg, 1'b0, limit_reg};
   wire [31:0] rd_st   = {19'h00000, ntc_on_reg, fault_pin_reg, emm_reg,
                          temp_cnt_reg, state_reg};
   wire [31:0] rd_data = hit_sch  ? rd_sch : hit_filt ? rd_filt : hit_st ? rd_st :
                         hit_esc  ? {24'h000000, esc_mask_reg} :
                         hit_diag ? {24'h000000, flags_reg} :
                         hit_wd   ? {25'h0000000, wd_reg} : 32'h00000000;

   // Scheduler conditions
   wire        normal_st  = (state_reg == ST_WAIT) | (state_reg == ST_SCAN);
   wire        in_scan    = (state_reg == ST_SCAN) | (state_reg == ST_SSCAN);
   wire        eval       = scan_done & in_scan;
   wire        eval_norm  = scan_done & (state_reg == ST_SCAN);
   wire        wait_zero  = wait_cyc_reg == 32'h00000000;
   wire        sleep_zero = sleep_cyc_reg == 64'h0;
   wire        sync_hit   = wr_acc & hit_wd & sync_reg & (state_reg == ST_WAIT);
   wire        hold_done  = hold_emm_reg ? emm_sent : wait_zero;
   wire [31:0] wait_load  = 32'(wait_cnt_reg) * WAIT_STEP_CYC;
   wire [63:0] sleep_load = 64'(sleep_ivl_reg) * SLEEP_STEP_CYC;
   wire        enter_scan = (state_next == ST_SCAN || state_next == ST_SSCAN)
                            && state_next != state_reg;
   wire        enter_slp  = state_next == ST_SLEEP && state_reg != ST_SLEEP;
   wire        enter_hold = state_next == ST_HOLD && state_reg != ST_HOLD;
   wire        first_next = wake_done | (state_next == ST_SSCAN);
   wire        temp_due   = temp_cnt_reg <= 4'h1;
   wire        all_off    = balance_en == 12'h000;
   wire [11:0] bal_fall   = bal_prev_reg & ~balance_en;
   wire        emm_want   = |(flags_reg & ~esc_mask_reg);

   // Fault set vector: six general sources plus balancing
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         set_vec[i] = eval & scan_result.fault[i] &
                      trip(gen_cnt_reg[i], limit_reg, filt_mask_reg[i]);
      end
      for (int c = 0; c < 12; c++) begin
         bal_uc_trip[c] = bal_snap_reg[c] & scan_result.bal_uc[c] &
                          trip(bal_cnt_reg[c], limit_reg, filt_mask_reg[6]);
         bal_oc_trip[c] = bal_snap_reg[c] & scan_result.bal_oc[c] &
                          trip(bal_cnt_reg[c], limit_reg, filt_mask_reg[7]);
      end
      set_vec[6] = eval & (|bal_uc_trip);
      set_vec[7] = eval & (|bal_oc_trip);
   end

   // flags set, host clear loses to set
   assign flags_next = (flags_reg & ~clr_vec) | set_vec;

   // Next state
   always_comb begin
      sched_state_t sleep_tgt;
      // zero interval means no periodic wake
      sleep_tgt  = (sleep_ivl_reg != 10'h000) ? ST_SLEEP : ST_OFF;
      state_next = state_reg;
      if (wake_done) begin
         state_next = ST_SCAN;
      end else begin
         unique case (state_reg)
            ST_OFF: state_next = ST_OFF;
            ST_WAIT:
               if (sleep_req) state_next = sleep_tgt;
               else if (wait_zero | sync_hit) state_next = ST_SCAN;
            ST_SCAN:
               if (sleep_req) state_next = sleep_tgt;
               else if (scan_done) state_next = ST_WAIT;
            ST_SLEEP: if (sleep_zero) state_next = ST_SSCAN;
            ST_SSCAN: begin
               // back to sleep, to hold on a flag, or on to normal
               if (scan_done) begin
                  if (wake_pend_reg | ext_wakeup) state_next = ST_WAIT;
                  else if (|flags_next) state_next = ST_HOLD;
                  else state_next = sleep_tgt;
               end
            end
            ST_HOLD: if (hold_done) state_next = sleep_tgt;
         endcase
      end
   end

   // APB slave flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg  <= 32'h00000000;
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg  <= setup;
         pslverr_reg <= setup & ~mapped;
         if (setup) prdata_reg <= rd_data;
      end
   end

   // Configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_cnt_reg  <= `RST_WAIT;
         sync_reg      <= 1'b0;
         filt_mask_reg <= `RST_FMSK;
         ntc_div_reg   <= `RST_NTC;
         limit_reg     <= `RST_LIMIT;
         sleep_ivl_reg <= `RST_SLEEP;
         esc_mask_reg  <= `RST_ESC;
         wd_reg        <= 7'h00;
      end else if (wr_acc) begin
         if (hit_sch) begin
            wait_cnt_reg  <= pwdata[`SCHED_WAIT_LSB +: 7];
            sync_reg      <= pwdata[`SCHED_SYNC_BIT];
            filt_mask_reg <= pwdata[`SCHED_FMSK_LSB +: 8];
            ntc_div_reg   <= pwdata[`SCHED_NTC_LSB +: 4];
         end
         if (hit_filt) begin
            limit_reg     <= pwdata[`FILT_LIM_LSB +: 3];
            sleep_ivl_reg <= pwdata[`FILT_SLP_LSB +: 10];
         end
         if (hit_esc) esc_mask_reg <= pwdata[7:0];
         if (hit_wd) wd_reg <= pwdata[6:0];
      end
   end

   // State and timers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg     <= ST_OFF;
         wait_cyc_reg  <= 32'h00000000;
         sleep_cyc_reg <= 64'h0;
         wake_pend_reg <= 1'b0;
         hold_emm_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (enter_scan) wait_cyc_reg <= wait_load;
         else if (enter_hold) wait_cyc_reg <= WD_MAX_CYC;
         else if (!wait_zero) wait_cyc_reg <= wait_cyc_reg - 32'h00000001;
         if (enter_slp) sleep_cyc_reg <= sleep_load;
         else if (!sleep_zero) sleep_cyc_reg <= sleep_cyc_reg - 64'h1;
         if (state_reg == ST_SSCAN) wake_pend_reg <= wake_pend_reg | ext_wakeup;
         else wake_pend_reg <= 1'b0;
         // emergency path or fault pin path
         if (enter_hold) hold_emm_reg <= |(flags_next & ~esc_mask_reg);
      end
   end

   // Scan start, NTC scheduling
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scan_start_reg <= 1'b0;
         ntc_meas_reg   <= 1'b0;
         ntc_on_reg     <= 1'b0;
         temp_cnt_reg   <= `RST_NTC;
         bal_snap_reg   <= 12'h000;
      end else begin
         scan_start_reg <= enter_scan;
         if (enter_scan) begin
            bal_snap_reg <= balance_en;
            // no NTC measure on first scan
            if (first_next) begin
               ntc_meas_reg <= 1'b0;
            end else begin
               ntc_meas_reg <= temp_due;
               temp_cnt_reg <= temp_due ? ntc_div_reg : temp_cnt_reg - 4'h1;
            end
         end else if (!in_scan) begin
            ntc_meas_reg <= 1'b0;
         end
         // current sources on before measuring scan
         ntc_on_reg <= ((state_reg == ST_WAIT) & temp_due &
                        (wait_cyc_reg <= SETTLE_CYC)) |
                       ((state_reg == ST_SCAN) & ntc_meas_reg & ~scan_done);
      end
   end

   // Diagnostic flags and general filter counters
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_reg <= 8'h00;
         for (int i = 0; i < 6; i++) gen_cnt_reg[i] <= 3'h0;
      end else begin
         flags_reg <= flags_next;
         for (int i = 0; i < 6; i++) begin
            if (eval & scan_result.fault[i]) gen_cnt_reg[i] <= sat_inc(gen_cnt_reg[i]);
            else if (eval_norm | clr_vec[i]) gen_cnt_reg[i] <= 3'h0;
         end
      end
   end

   // Per-cell balancing filter counters
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bal_prev_reg <= 12'h000;
         for (int c = 0; c < 12; c++) bal_cnt_reg[c] <= 3'h0;
      end else begin
         bal_prev_reg <= balance_en;
         for (int c = 0; c < 12; c++) begin
            if (eval & bal_snap_reg[c] & (scan_result.bal_oc[c] | scan_result.bal_uc[c]))
               bal_cnt_reg[c] <= sat_inc(bal_cnt_reg[c]);
            else if (eval_norm | clr_vec[6] | clr_vec[7])
               bal_cnt_reg[c] <= 3'h0;
            // clear on stop unless all stopped
            else if (~filt_mask_reg[7] & bal_fall[c] & ~all_off)
               bal_cnt_reg[c] <= 3'h0;
         end
      end
   end

   // Emergency signalling and fault pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         emm_reg       <= 1'b0;
         fault_pin_reg <= 1'b0;
      end else begin
         // driven from stored flags, one cycle after set
         emm_reg <= normal_st ? emm_want :
                    (state_reg == ST_HOLD) & hold_emm_reg & ~emm_sent;
         fault_pin_reg <= (state_reg == ST_HOLD) & ~hold_emm_reg & ~wait_zero;
      end
   end

   assign prdata               = prdata_reg;
   assign pready               = pready_reg;
   assign pslverr              = pslverr_reg;
   assign scan_start           = scan_start_reg;
   assign ntc_measure          = ntc_meas_reg;
   assign ntc_current_on       = ntc_on_reg;
   assign emergency_signalling = emm_reg;
   assign fault_pin            = fault_pin_reg;

   a_wait_reload: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg == ST_WAIT && state_next == ST_SCAN) |=>
         (scan_start_reg && wait_cyc_reg == $past(wait_load)))
      else $error("wait counter not reloaded at scan start");
   a_flag_trip: assert property (@(posedge pclk) disable iff (!presetn)
      (eval && scan_result.fault[0] && !filt_mask_reg[0] &&
       sat_inc(gen_cnt_reg[0]) > limit_reg) |=> flags_reg[0])
      else $error("flag not set past limit");
   a_cnt_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (eval_norm && !scan_result.fault[1]) |=> gen_cnt_reg[1] == 3'h0)
      else $error("counter kept after clean scan");
   a_emm_entry: assert property (@(posedge pclk) disable iff (!presetn)
      (normal_st && emm_want) |=> emergency_signalling)
      else $error("emergency not started");
   a_sleep_quiet: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg == ST_SLEEP && state_next == ST_SLEEP) |=> !scan_start_reg)
      else $error("scan during sleep");
   a_first_skip: assert property (@(posedge pclk) disable iff (!presetn)
      wake_done |=> (!ntc_meas_reg && scan_start_reg) [*1] ##1 !ntc_meas_reg)
      else $error("NTC measured on first scan");
   a_sleep_off: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg == ST_WAIT && sleep_req && !wake_done && sleep_ivl_reg == 10'h000)
         |=> state_reg == ST_OFF)
      else $error("periodic wake while disabled");
   a_bal_keep: assert property (@(posedge pclk) disable iff (!presetn)
      (all_off && bal_prev_reg != 12'h000 && !eval && !clr_vec[6] && !clr_vec[7])
         |=> bal_cnt_reg[0] == $past(bal_cnt_reg[0]))
      else $error("balancing counter lost");
   a_sync_scan: assert property (@(posedge pclk) disable iff (!presetn)
      (sync_hit && !wake_done && !sleep_req) |=> scan_start_reg)
      else $error("watchdog write did not start scan");

endmodule // diag_scan_scheduler

// [design/diag_scan_defines.svh]
// Register offsets, field positions, reset values and timing figures
`ifndef DIAG_SCAN_DEFINES_SVH
`define DIAG_SCAN_DEFINES_SVH
// Register byte offsets
`define OFS_SCHED      12'h000
`define OFS_FILT       12'h004
`define OFS_ESC_MASK   12'h008
`define OFS_DIAG       12'h00c
`define OFS_WD         12'h010
`define OFS_STATUS     12'h014
// scheduler_config_reg fields
`define SCHED_WAIT_LSB 0
`define SCHED_SYNC_BIT 7
`define SCHED_FMSK_LSB 8
`define SCHED_NTC_LSB  16
// fault_filter_config_reg fields
`define FILT_LIM_LSB   0
`define FILT_SLP_LSB   4
// Reset values
`define RST_WAIT       7'h7f
`define RST_FMSK       8'h80
`define RST_NTC        4'h3
`define RST_LIMIT      3'h0
`define RST_SLEEP      10'h000
`define RST_ESC        8'h00
// Timing figures in their own units
`define CLK_NS         40
`define WAIT_STEP_US   1170
`define SETTLE_MS      40
`define WD_MAX_MS      2030
`define SLEEP_STEP_MIN 10
`endif

// [design/diag_scan_pkg.sv]
// Types shared by the scan scheduler
package diag_scan_pkg;
   // Scheduler states, one-hot
   typedef enum logic [5:0] {
      ST_OFF   = 6'b000001,
      ST_WAIT  = 6'b000010,
      ST_SCAN  = 6'b000100,
      ST_SLEEP = 6'b001000,
      ST_SSCAN = 6'b010000,
      ST_HOLD  = 6'b100000
   } sched_state_t;
   // Results reported by the analog side at scan end
   typedef struct packed {
      logic [5:0]  fault;
      logic [11:0] bal_oc;
      logic [11:0] bal_uc;
   } scan_result_t;
endpackage

// [testbench/tb_diag_scan_scheduler.sv]
// Self-checking testbench for the diagnostic scan scheduler
`timescale 1ns/1ps
module tb_diag_scan_scheduler;
   import diag_scan_pkg::*;
   logic         pclk, presetn, psel, penable, pwrite;
   logic [11:0]  paddr;
   logic [31:0]  pwdata, prdata;
   logic         pready, pslverr;
   logic         wake_done, sleep_req, ext_wakeup, scan_done, emm_sent;
   scan_result_t scan_result;
   logic [11:0]  balance_en;
   logic         scan_start, ntc_measure, ntc_current_on, emergency_signalling, fault_pin;
   int           fails, compares;
   logic [31:0]  rd;
   logic         err, m, cur;
   int           n;

   // Design with shortened timing counts
   diag_scan_scheduler #(.WAIT_STEP_CYC(4), .SETTLE_CYC(10), .WD_MAX_CYC(20),
      .SLEEP_STEP_CYC(30)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .wake_done(wake_done), .sleep_req(sleep_req),
      .ext_wakeup(ext_wakeup), .scan_done(scan_done), .scan_result(scan_result),
      .balance_en(balance_en), .emm_sent(emm_sent), .scan_start(scan_start),
      .ntc_measure(ntc_measure), .ntc_current_on(ntc_current_on),
      .emergency_signalling(emergency_signalling), .fault_pin(fault_pin));

   // Clock, 40 ns period
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   // Verdict and end of run
   task automatic end_sim();
      $display("Checks %0d mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // Compare and report
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One APB transfer, waits for pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      forever begin
         @(posedge pclk);
         if (pready === 1'b1) break;
         k++;
         if (k > 20) begin
            fails++;
            $display("Error pready expected 1 seen 0");
            end_sim();
         end
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask

   // Wait for a scan start, answer it with a result
   task automatic do_scan(input int lim, input logic [5:0] f, input logic [11:0] oc);
      n = 0;
      forever begin
         @(posedge pclk);
         if (scan_start === 1'b1) break;
         n++;
         if (n > lim) begin
            fails++;
            $display("Error scan_start expected 1 seen 0");
            end_sim();
         end
      end
      m = ntc_measure;
      cur = ntc_current_on;
      scan_result <= '{fault: f, bal_oc: oc, bal_uc: 12'h000};
      scan_done <= 1'b1;
      @(posedge pclk);
      scan_done <= 1'b0;
   endtask

   // Reset values and unmapped access
   task automatic t_reset();
      apb(1'b0, 12'h000, 32'h0); chk("sched_rst", 32'h0003807f, rd);
      apb(1'b0, 12'h004, 32'h0); chk("filt_rst", 32'h0, rd);
      apb(1'b0, 12'h020, 32'h0); chk("unmapped_err", 32'h1, {31'h0, err});
      chk("unmapped_rd", 32'h0, rd);
   endtask

   // First scan at wake-up, then periodic gap
   task automatic t_wake();
      apb(1'b1, 12'h000, 32'h0003800a);
      apb(1'b1, 12'h004, 32'h00000001);
      wake_done <= 1'b1;
      @(posedge pclk);
      wake_done <= 1'b0;
      do_scan(3, 6'h00, 12'h000);
      chk("first_ntc", 32'h0, {31'h0, m});
      do_scan(60, 6'h00, 12'h000);
      chk("wait_gap", 32'h1, {31'h0, (n >= 36 && n <= 41)});
   endtask

   // Filter counters, flags, emergency and host clear
   task automatic t_filter();
      do_scan(60, 6'h01, 12'h000);
      chk("ntc_skip", 32'h0, {31'h0, m});
      chk("ntc_cur_off", 32'h0, {31'h0, cur});
      apb(1'b0, 12'h00c, 32'h0); chk("flag_one", 32'h0, rd);
      do_scan(60, 6'h01, 12'h000);
      chk("ntc_due", 32'h1, {31'h0, m});
      chk("ntc_cur_on", 32'h1, {31'h0, cur});
      apb(1'b0, 12'h00c, 32'h0); chk("flag_two", 32'h1, rd);
      chk("emerg_on", 32'h1, {31'h0, emergency_signalling});
      apb(1'b1, 12'h00c, 32'h1);
      apb(1'b0, 12'h00c, 32'h0); chk("flag_clr", 32'h0, rd);
      chk("emerg_off", 32'h0, {31'h0, emergency_signalling});
      do_scan(60, 6'h01, 12'h000);
      apb(1'b0, 12'h00c, 32'h0); chk("cnt_host_clr", 32'h0, rd);
      do_scan(60, 6'h00, 12'h000);
      do_scan(60, 6'h01, 12'h000);
      apb(1'b0, 12'h00c, 32'h0); chk("cnt_clean_clr", 32'h0, rd);
   endtask

   // Balancing checks only on balancing cells, overcurrent unfiltered
   task automatic t_bal();
      balance_en <= 12'h001;
      do_scan(60, 6'h00, 12'h002);
      apb(1'b0, 12'h00c, 32'h0); chk("bal_idle_cell", 32'h0, rd);
      do_scan(60, 6'h00, 12'h001);
      apb(1'b0, 12'h00c, 32'h0); chk("bal_oc_flag", 32'h80, rd);
      apb(1'b1, 12'h00c, 32'h80);
      balance_en <= 12'h000;
   endtask

   // Watchdog write starts a scan when synchronised
   task automatic t_sync();
      apb(1'b1, 12'h000, 32'h000380ff);
      do_scan(60, 6'h00, 12'h000);
      apb(1'b1, 12'h010, 32'h10);
      do_scan(4, 6'h00, 12'h000);
   endtask

   // Periodic sleep scan, back to sleep
   task automatic t_sleep();
      apb(1'b1, 12'h004, 32'h00000011);
      sleep_req <= 1'b1;
      @(posedge pclk);
      sleep_req <= 1'b0;
      apb(1'b0, 12'h014, 32'h0); chk("sleep_state", 32'h8, rd & 32'h3f);
      do_scan(60, 6'h00, 12'h000);
      chk("sleep_gap", 32'h1, {31'h0, (n >= 15 && n <= 40)});
      chk("sleep_ntc", 32'h0, {31'h0, m});
      repeat (2) @(posedge pclk);
      apb(1'b0, 12'h014, 32'h0); chk("resleep", 32'h8, rd & 32'h3f);
   endtask

   // Sleep scan with an escalation-masked fault: fault pin, then sleep
   task automatic t_hold();
      apb(1'b1, 12'h008, 32'h00000001);
      apb(1'b1, 12'h004, 32'h00000010);
      do_scan(60, 6'h01, 12'h000);
      repeat (2) @(posedge pclk);
      chk("hold_pin", 32'h1, {31'h0, fault_pin});
      chk("hold_emerg", 32'h0, {31'h0, emergency_signalling});
      apb(1'b0, 12'h014, 32'h0); chk("hold_state", 32'h20, rd & 32'h3f);
      chk("hold_pin_mid", 32'h1, {31'h0, fault_pin});
      repeat (20) @(posedge pclk);
      chk("hold_pin_off", 32'h0, {31'h0, fault_pin});
      apb(1'b0, 12'h014, 32'h0); chk("hold_sleep", 32'h8, rd & 32'h3f);
      apb(1'b0, 12'h00c, 32'h0); chk("hold_flag", 32'h1, rd);
   endtask

   // Main sequence
   initial begin
      fails = 0; compares = 0;
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 12'h000; pwdata = 32'h0; wake_done = 1'b0; sleep_req = 1'b0;
      ext_wakeup = 1'b0; scan_done = 1'b0; scan_result = '0; balance_en = 12'h000;
      emm_sent = 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_wake();
      t_filter();
      t_bal();
      t_sync();
      t_sleep();
      t_hold();
      end_sim();
   end
endmodule // tb_diag_scan_scheduler
